// ==== rtl/wiper_pkg.sv ====
// shared constants and types for the wiper register serial link
`default_nettype none
package wiper_pkg;
  // ----------------------------------------
  // byte formats
  // ----------------------------------------
  localparam logic [6:0] ID_UPPER    = 7'h28;
  localparam logic       READ_BIT    = 1'h1;
  localparam logic       WRITE_BIT   = 1'h0;
  localparam logic [7:0] WIPER_ADDR  = 8'h00;
  localparam logic [7:0] WIPER_RESET = 8'h80;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] LAST_BIT    = 4'h7;
  // ----------------------------------------
  // master byte slots
  // ----------------------------------------
  localparam logic [1:0] IDX_ID    = 2'h0;
  localparam logic [1:0] IDX_ADDR  = 2'h1;
  localparam logic [1:0] IDX_THIRD = 2'h2;
  localparam logic [1:0] IDX_RX    = 2'h3;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int         CLK_PERIOD_NS   = 4;
  localparam int         SCL_PERIOD_NS   = 160;
  localparam int         SCL_HALF_CYCLES = SCL_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [7:0] SCL_HALF_LAST   = 8'(SCL_HALF_CYCLES - 1);
  // ----------------------------------------
  // state encodings
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ID   = 3'h1,
    S_ADDR = 3'h2,
    S_DATA = 3'h3,
    S_TX   = 3'h4,
    S_MACK = 3'h5
  } slave_state_type;
  typedef enum logic [3:0] {
    M_IDLE    = 4'h0,
    M_START_A = 4'h1,
    M_START_B = 4'h2,
    M_LOW     = 4'h3,
    M_HIGH    = 4'h4,
    M_RESTART = 4'h5,
    M_STOP_A  = 4'h6,
    M_STOP_B  = 4'h7,
    M_STOP_C  = 4'h8
  } master_state_type;
endpackage
`default_nettype wire

// ==== rtl/wiper_bus_if.sv ====
// two-wire open-drain bus joining the master and the potentiometer slave
`default_nettype none
interface wiper_bus_if;
  logic sclOe;
  logic sdaMasterOe;
  logic sdaSlaveOe;
  logic scl;
  logic sda;
  // ----------------------------------------
  // wired-and with pull-ups: an enable pulls the line low
  // ----------------------------------------
  assign scl = ~sclOe;
  assign sda = ~(sdaMasterOe | sdaSlaveOe);
  modport master (output sclOe, output sdaMasterOe, input scl, input sda);
  modport device (output sdaSlaveOe, input scl, input sda);
endinterface
`default_nettype wire

// ==== rtl/pin_sync.sv ====
// two-flop synchroniser for the bus lines with edge, start and stop detection
`default_nettype none
module pin_sync (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic sclPin,
  input  wire logic sdaPin,
  output logic      sclS,
  output logic      sdaS,
  output logic      sclRise,
  output logic      sclFall,
  output logic      startSeen,
  output logic      stopSeen
);
  logic [1:0] meta_r;
  logic [1:0] sync_r;
  logic [1:0] prev_r;
  // ----------------------------------------
  // idle bus reads high, so reset to high avoids a false start
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      meta_r <= 2'h3;
      sync_r <= 2'h3;
      prev_r <= 2'h3;
    end else begin
      meta_r <= {sclPin, sdaPin};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  assign sclS      = sync_r[1];
  assign sdaS      = sync_r[0];
  assign sclRise   = sync_r[1] & ~prev_r[1];
  assign sclFall   = ~sync_r[1] & prev_r[1];
  // both clock samples high so a simultaneous scl fall is not taken as start
  assign startSeen = sync_r[1] & prev_r[1] & prev_r[0] & ~sync_r[0];
  assign stopSeen  = sync_r[1] & prev_r[1] & ~prev_r[0] & sync_r[0];
endmodule
`default_nettype wire

// ==== rtl/wiper_slave.sv ====
// potentiometer end: serial slave holding the 8-bit wiper position register
`default_nettype none
//
// Contract
// - identification upper seven bits 0101000, LSB read
// - all bytes shifted MSB first
// - wiper register resets to 80h
// - master sends address 00h after identification
// - every access maps to wiper at 00h
// - write: id, address, data; each acknowledged
// - after write and STOP, return to standby
// - update only with valid bytes, full count
// - write data shifts into separate register
// - commit on falling edge of LSB pulse
// - read: id, address, restart, id read; acked
// - keep sending while master acknowledges
// - master ends read with no-ack, STOP
module wiper_slave
  import wiper_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  rst_b,
  wiper_bus_if.device bus,
  output logic [7:0] wiperPos
);
  typedef struct packed {
    slave_state_type state;
    slave_state_type after;
    logic            ackPhase;
    logic [3:0]      bitCnt;
    logic [7:0]      shift;
    logic [7:0]      wiper;
    logic            addrOk;
    logic            sdaOe;
    logic            mAck;
  } slave_regs_type;

  slave_regs_type r_r;
  slave_regs_type r_nxt;
  logic           sclS;
  logic           sdaS;
  logic           sclRise;
  logic           sclFall;
  logic           startSeen;
  logic           stopSeen;
  logic           byteOk;

  // ----------------------------------------
  // line synchroniser
  // ----------------------------------------
  pin_sync lines (
    .clock     (clock),
    .rst_b     (rst_b),
    .sclPin    (bus.scl),
    .sdaPin    (bus.sda),
    .sclS      (sclS),
    .sdaS      (sdaS),
    .sclRise   (sclRise),
    .sclFall   (sclFall),
    .startSeen (startSeen),
    .stopSeen  (stopSeen)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    r_nxt  = r_r;
    byteOk = 1'b0;
    if (stopSeen) begin
      r_nxt.state    = S_IDLE;
      r_nxt.ackPhase = 1'b0;
      r_nxt.sdaOe    = 1'b0;
      r_nxt.addrOk   = 1'b0;
    end else if (startSeen) begin
      // a repeated start keeps addrOk so the read can follow the address
      r_nxt.state    = S_ID;
      r_nxt.bitCnt   = 4'h0;
      r_nxt.ackPhase = 1'b0;
      r_nxt.sdaOe    = 1'b0;
    end else begin
      case (r_r.state)
        S_ID, S_ADDR, S_DATA: begin
          if (r_r.ackPhase) begin
            if (sclFall) begin
              r_nxt.ackPhase = 1'b0;
              r_nxt.sdaOe    = 1'b0;
              r_nxt.bitCnt   = 4'h0;
              r_nxt.state    = r_r.after;
              if (r_r.after == S_TX) begin
                r_nxt.shift = r_r.wiper;
                r_nxt.sdaOe = ~r_r.wiper[7];
              end
            end
          end else if (sclRise && r_r.bitCnt < BYTE_BITS) begin
            r_nxt.shift  = {r_r.shift[6:0], sdaS};
            r_nxt.bitCnt = r_r.bitCnt + 4'h1;
          end else if (sclFall && r_r.bitCnt == BYTE_BITS) begin
            r_nxt.bitCnt = 4'h0;
            case (r_r.state)
              S_ID: begin
                if (r_r.shift[7:1] == ID_UPPER) begin
                  if (r_r.shift[0] == READ_BIT) begin
                    byteOk      = r_r.addrOk;
                    r_nxt.after = S_TX;
                  end else begin
                    byteOk      = 1'b1;
                    r_nxt.after = S_ADDR;
                  end
                end
              end
              S_ADDR: begin
                if (r_r.shift == WIPER_ADDR) begin
                  byteOk       = 1'b1;
                  r_nxt.addrOk = 1'b1;
                  r_nxt.after  = S_DATA;
                end
              end
              default: begin
                // committed on the fall that ends the LSB pulse
                byteOk      = 1'b1;
                r_nxt.wiper = r_r.shift;
                r_nxt.after = S_IDLE;
              end
            endcase
            if (byteOk) begin
              r_nxt.ackPhase = 1'b1;
              r_nxt.sdaOe    = 1'b1;
            end else begin
              r_nxt.state = S_IDLE;
            end
          end
        end
        S_TX: begin
          if (sclFall) begin
            if (r_r.bitCnt == LAST_BIT) begin
              r_nxt.sdaOe  = 1'b0;
              r_nxt.bitCnt = 4'h0;
              r_nxt.state  = S_MACK;
            end else begin
              r_nxt.shift  = {r_r.shift[6:0], 1'b0};
              r_nxt.sdaOe  = ~r_r.shift[6];
              r_nxt.bitCnt = r_r.bitCnt + 4'h1;
            end
          end
        end
        S_MACK: begin
          if (sclRise) begin
            r_nxt.mAck = ~sdaS;
          end
          if (sclFall) begin
            if (r_r.mAck) begin
              r_nxt.state = S_TX;
              r_nxt.shift = r_r.wiper;
              r_nxt.sdaOe = ~r_r.wiper[7];
            end else begin
              r_nxt.state = S_IDLE;
            end
          end
        end
        default: begin
          r_nxt.sdaOe = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      r_r          <= '0;
      r_r.state    <= S_IDLE;
      r_r.after    <= S_IDLE;
      r_r.wiper    <= WIPER_RESET;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign bus.sdaSlaveOe = r_r.sdaOe;
  assign wiperPos       = r_r.wiper;
endmodule
`default_nettype wire

// ==== rtl/wiper_master.sv ====
// bus master end: issues single-byte writes and reads of the wiper register
`default_nettype none
module wiper_master
  import wiper_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_b,
  wiper_bus_if.master     bus,
  input  wire logic       cmdValid,
  input  wire logic       cmdRead,
  input  wire logic [7:0] cmdData,
  output logic            cmdReady,
  output logic            rspValid,
  output logic [7:0]      rspData,
  output logic            rspNack
);
  typedef struct packed {
    master_state_type state;
    logic [7:0]       div;
    logic [1:0]       idx;
    logic [3:0]       bitCnt;
    logic [7:0]       tx;
    logic [7:0]       rx;
    logic             read;
    logic [7:0]       data;
    logic             sclOe;
    logic             sdaOe;
    logic             rspValid;
    logic [7:0]       rspData;
    logic             nack;
  } master_regs_type;

  master_regs_type r_r;
  master_regs_type r_nxt;
  logic            sdaS;
  logic            tick;

  function automatic logic [7:0] slotByte(input logic [1:0] idx, input logic rd, input logic [7:0] d);
    logic [7:0] b;
    b = d;
    if (idx == IDX_ID) b = {ID_UPPER, WRITE_BIT};
    if (idx == IDX_ADDR) b = WIPER_ADDR;
    if (idx == IDX_THIRD && rd) b = {ID_UPPER, READ_BIT};
    if (idx == IDX_RX) b = 8'hff;
    return b;
  endfunction

  pin_sync lines (
    .clock     (clock),
    .rst_b     (rst_b),
    .sclPin    (bus.scl),
    .sdaPin    (bus.sda),
    .sclS      (),
    .sdaS      (sdaS),
    .sclRise   (),
    .sclFall   (),
    .startSeen (),
    .stopSeen  ()
  );

  // ----------------------------------------
  // half-period divider, one tick per scl phase
  // ----------------------------------------
  assign tick = (r_r.div == SCL_HALF_LAST);

  always_comb begin
    r_nxt          = r_r;
    r_nxt.rspValid = 1'b0;
    r_nxt.div      = (tick || r_r.state == M_IDLE) ? 8'h00 : r_r.div + 8'h01;
    case (r_r.state)
      M_IDLE: begin
        r_nxt.sclOe = 1'b0;
        r_nxt.sdaOe = 1'b0;
        if (cmdValid) begin
          r_nxt.read  = cmdRead;
          r_nxt.data  = cmdData;
          r_nxt.idx   = IDX_ID;
          r_nxt.nack  = 1'b0;
          r_nxt.state = M_START_A;
        end
      end
      M_START_A: begin
        r_nxt.sclOe = 1'b0;
        r_nxt.sdaOe = 1'b0;
        if (tick) r_nxt.state = M_START_B;
      end
      M_START_B: begin
        r_nxt.sdaOe = 1'b1;
        if (tick) begin
          r_nxt.tx     = slotByte(r_r.idx, r_r.read, r_r.data);
          r_nxt.bitCnt = 4'h0;
          r_nxt.state  = M_LOW;
        end
      end
      M_LOW: begin
        r_nxt.sclOe = 1'b1;
        // ack slot: release after a sent byte, no-ack after the read byte
        r_nxt.sdaOe = (r_r.bitCnt == BYTE_BITS) ? 1'b0 : ~r_r.tx[7];
        if (tick) r_nxt.state = M_HIGH;
      end
      M_HIGH: begin
        r_nxt.sclOe = 1'b0;
        if (tick) begin
          r_nxt.state = M_LOW;
          if (r_r.bitCnt == BYTE_BITS) begin
            if (r_r.idx == IDX_RX) begin
              r_nxt.rspValid = 1'b1;
              r_nxt.rspData  = r_r.rx;
              r_nxt.state    = M_STOP_A;
            end else if (sdaS) begin
              r_nxt.nack  = 1'b1;
              r_nxt.state = M_STOP_A;
            end else if (r_r.idx == IDX_THIRD && !r_r.read) begin
              r_nxt.state = M_STOP_A;
            end else begin
              r_nxt.idx    = r_r.idx + 2'h1;
              r_nxt.bitCnt = 4'h0;
              r_nxt.tx     = slotByte(r_r.idx + 2'h1, r_r.read, r_r.data);
              if (r_r.idx == IDX_ADDR && r_r.read) r_nxt.state = M_RESTART;
            end
          end else begin
            r_nxt.rx     = {r_r.rx[6:0], sdaS};
            r_nxt.tx     = {r_r.tx[6:0], 1'b1};
            r_nxt.bitCnt = r_r.bitCnt + 4'h1;
          end
        end
      end
      M_RESTART: begin
        // release data while clock is low so the rise is not a stop
        r_nxt.sclOe = 1'b1;
        r_nxt.sdaOe = 1'b0;
        if (tick) r_nxt.state = M_START_A;
      end
      M_STOP_A: begin
        r_nxt.sclOe = 1'b1;
        r_nxt.sdaOe = 1'b1;
        if (tick) r_nxt.state = M_STOP_B;
      end
      M_STOP_B: begin
        r_nxt.sclOe = 1'b0;
        if (tick) r_nxt.state = M_STOP_C;
      end
      M_STOP_C: begin
        r_nxt.sdaOe = 1'b0;
        if (tick) r_nxt.state = M_IDLE;
      end
      default: begin
        r_nxt.state = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      r_r       <= '0;
      r_r.state <= M_IDLE;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign bus.sclOe       = r_r.sclOe;
  assign bus.sdaMasterOe = r_r.sdaOe;
  assign cmdReady        = (r_r.state == M_IDLE);
  assign rspValid        = r_r.rspValid;
  assign rspData         = r_r.rspData;
  assign rspNack         = r_r.nack;
endmodule
`default_nettype wire

// ==== sim/wiper_monitor.sv ====
// bus protocol checker for the wiper serial link
`default_nettype none
module wiper_monitor
  import wiper_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic sclOe,
  input wire logic sdaMasterOe,
  input wire logic sdaSlaveOe,
  input wire logic scl,
  input wire logic sda
);
  logic       sclQ, sdaQ, live, rdMode, addrOk, expAck;
  logic [3:0] bitCnt;
  logic [1:0] byteIdx;
  logic [7:0] shReg, shadow;
  wire logic  rise    = scl & ~sclQ;
  wire logic  startEv = scl & sclQ & sdaQ & ~sda;
  wire logic  stopEv  = scl & sclQ & ~sdaQ & sda;
  wire logic  ackRise = rise & (bitCnt == 4'h8);
  wire logic  txByte  = live & rdMode & (byteIdx != 2'h0);
  // ----------------------------------------
  // shadow of the transfer, rebuilt from the wires alone
  // ----------------------------------------
  always_comb begin
    expAck = 1'b0;
    if (byteIdx == 2'h0) expAck = (shReg[7:1] == ID_UPPER) & (~shReg[0] | addrOk);
    else if (live & ~rdMode) expAck = (byteIdx == 2'h1) ? (shReg == WIPER_ADDR) : (byteIdx == 2'h2) & addrOk;
  end
  always_ff @(posedge clock) begin
    sclQ <= scl | ~rst_b;
    sdaQ <= sda | ~rst_b;
    if (!rst_b | startEv | stopEv) begin
      bitCnt <= 4'h0;
      byteIdx <= 2'h0;
      live <= 1'b0;
    end else if (rise) begin
      bitCnt <= ackRise ? 4'h0 : bitCnt + 4'h1;
      if (!ackRise) shReg <= {shReg[6:0], sda};
      if (ackRise & byteIdx != 2'h3) byteIdx <= byteIdx + 2'h1;
      if (ackRise) live <= txByte ? ~sda : expAck & ~(byteIdx == 2'h2 & ~rdMode);
      if (ackRise & byteIdx == 2'h0) rdMode <= shReg[0];
      if (ackRise & byteIdx == 2'h1 & ~rdMode) addrOk <= expAck;
      if (ackRise & byteIdx == 2'h2 & expAck) shadow <= shReg;
    end
    if (!rst_b | stopEv) addrOk <= 1'b0;
    if (!rst_b) begin
      shReg <= 8'h00;
      shadow <= WIPER_RESET;
      rdMode <= 1'b0;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_stop; stopEv; endsequence
  sequence s_quiet; !sdaSlaveOe [*8]; endsequence
  sequence s_ack_held; (sdaSlaveOe & ~sda) [*8]; endsequence
  chk_ack_given: assert property (ackRise & expAck |-> s_ack_held)
    else $error("slave ack missing");
  chk_ack_withheld: assert property (ackRise & ~expAck & ~txByte |-> !sdaSlaveOe)
    else $error("slave acked a refused byte");
  chk_rx_released: assert property (rise & ~txByte & bitCnt != 4'h8 |-> !sdaSlaveOe)
    else $error("slave drove sda while receiving");
  chk_read_bits: assert property (rise & txByte & bitCnt != 4'h8 |-> sda == shadow[~bitCnt[2:0]])
    else $error("read bit differs from wiper shadow");
  chk_tx_release: assert property (ackRise & txByte |-> !sdaSlaveOe && sda)
    else $error("master ack slot not released");
  chk_nack_stop: assert property (ackRise & txByte & sda |-> ##[1:200] stopEv)
    else $error("no stop after master nack");
  chk_slave_edge: assert property ($changed(sdaSlaveOe) |-> !scl)
    else $error("slave changed sda with scl high");
  chk_stop_standby: assert property (s_stop |=> s_quiet)
    else $error("slave active after stop");
endmodule
`default_nettype wire

// ==== sim/tb_wiper_register_serial_slave.sv ====
// self-checking bench: master and slave joined, plus a scripted master on a second bus
`default_nettype none
`define CHECK(what, exp, act) begin checked++; if ((act) !== (exp)) begin n_mismatch++; \
  $display("MISMATCH %s expected %h seen %h", what, exp, act); end end
module tb_wiper_register_serial_slave
  import wiper_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock = 1'b0, rst_b = 1'b0, cmdValid = 1'b0, cmdRead = 1'b0;
  logic       cmdReady, rspValid, rspNack;
  logic [7:0] cmdData = 8'h00, rspData, wiperPos, wiperPos2, model, model2, got, sh;
  logic [7:0] seen[$];
  int         n_mismatch = 0, checked = 0, bitN = 0;
  wiper_bus_if busA ();
  wiper_bus_if busB ();
  wiper_master wiper_master_inst (.clock(clock), .rst_b(rst_b), .bus(busA), .cmdValid(cmdValid),
    .cmdRead(cmdRead), .cmdData(cmdData), .cmdReady(cmdReady), .rspValid(rspValid),
    .rspData(rspData), .rspNack(rspNack));
  wiper_slave wiper_slave_inst (.clock(clock), .rst_b(rst_b), .bus(busA), .wiperPos(wiperPos));
  // the second slave faces the bench, which breaks the bus order on purpose
  wiper_slave wiper_slave_inst2 (.clock(clock), .rst_b(rst_b), .bus(busB), .wiperPos(wiperPos2));
  wiper_monitor wiper_monitor_inst (.clock(clock), .rst_b(rst_b), .sclOe(busA.sclOe),
    .sdaMasterOe(busA.sdaMasterOe), .sdaSlaveOe(busA.sdaSlaveOe), .scl(busA.scl), .sda(busA.sda));
  always #2 clock = ~clock;
  // ----------------------------------------
  // byte sniffer on the joined bus
  // ----------------------------------------
  // sampled on the clock: sda and scl can move in one step, so line events would race
  logic sclQ = 1'b1, sdaQ = 1'b1;
  always @(posedge clock) begin
    if (sclQ && busA.scl && sdaQ && !busA.sda) bitN = 0;
    else if (!sclQ && busA.scl) begin
      if (bitN < 8) sh = {sh[6:0], busA.sda};
      if (bitN == 7) seen.push_back(sh);
      bitN = (bitN == 8) ? 0 : bitN + 1;
    end
    sclQ = busA.scl;
    sdaQ = busA.sda;
  end
  function automatic logic [7:0] wire_byte(int i, logic rd, logic [7:0] d);
    logic [7:0] t[4];
    t = '{{ID_UPPER, WRITE_BIT}, WIPER_ADDR, rd ? {ID_UPPER, READ_BIT} : d, d};
    return t[i];
  endfunction
  function automatic logic [2:0] exp_acks(logic [7:0] id, logic [7:0] a);
    logic ok;
    ok = (id == {ID_UPPER, WRITE_BIT});
    return {ok & (a == WIPER_ADDR), ok & (a == WIPER_ADDR), ok};
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmd(input logic rd, input logic [7:0] d);
    seen.delete();
    @(posedge clock);
    cmdValid <= 1'b1;
    cmdRead <= rd;
    cmdData <= d;
    @(posedge clock);
    cmdValid <= 1'b0;
    got = 8'hxx;
    for (int n = 0; n < 3000; n++) begin
      @(posedge clock);
      if (rspValid) got = rspData;
      if (cmdReady) break;
    end
    `CHECK("done", 1'b1, cmdReady)
    `CHECK("nack", 1'b0, rspNack)
    if (rd) `CHECK("read", model, got)
    else model = d;
    `CHECK("wiper", model, wiperPos)
    `CHECK("count", rd ? 4 : 3, seen.size())
    foreach (seen[i]) `CHECK("wire", wire_byte(i, rd, model), seen[i])
  endtask
  // ----------------------------------------
  // scripted master on the second bus
  // ----------------------------------------
  task automatic bb_half();
    repeat (SCL_HALF_CYCLES) @(posedge clock);
  endtask
  task automatic bb_bit(input logic b, output logic s);
    busB.sdaMasterOe <= ~b;
    bb_half();
    busB.sclOe <= 1'b0;
    bb_half();
    s = busB.sda;
    busB.sclOe <= 1'b1;
  endtask
  task automatic bb_xfer(input logic [7:0] id, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v[3];
    logic [2:0] acks;
    logic       s;
    v = '{id, a, d};
    bb_half();
    busB.sdaMasterOe <= 1'b1;
    bb_half();
    busB.sclOe <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      for (int i = 7; i >= 0; i--) begin
        if (k == 2 && i == 0) begin
          repeat (4) @(posedge clock);
          `CHECK("shift", model2, wiperPos2)
        end
        bb_bit(v[k][i], s);
      end
      // wiper must follow within a few cycles of the lsb fall, well before the ack pulse
      repeat (8) @(posedge clock);
      if (k == 2 && &exp_acks(id, a)) model2 = d;
      if (k == 2) `CHECK("commit", model2, wiperPos2)
      bb_bit(1'b1, s);
      acks[k] = ~s;
    end
    busB.sdaMasterOe <= 1'b1;
    bb_half();
    busB.sclOe <= 1'b0;
    bb_half();
    busB.sdaMasterOe <= 1'b0;
    bb_half();
    `CHECK("acks", exp_acks(id, a), acks)
  endtask
  task automatic bb_byte(input logic [7:0] v, input logic ackOut, output logic [7:0] r, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bb_bit(v[i], s);
      r[i] = s;
    end
    repeat (8) @(posedge clock);
    bb_bit(ackOut, s);
    ack = ~s;
  endtask
  // combined read with master acks, so the slave must keep sending
  task automatic bb_read();
    logic [7:0] r;
    logic       a;
    for (int k = 0; k < 2; k++) begin
      busB.sdaMasterOe <= 1'b0;
      bb_half();
      busB.sclOe <= 1'b0;
      bb_half();
      busB.sdaMasterOe <= 1'b1;
      bb_half();
      busB.sclOe <= 1'b1;
      bb_byte({ID_UPPER, ((k == 1) ? READ_BIT : WRITE_BIT)}, 1'b1, r, a);
      `CHECK("rd id ack", 1'b1, a)
      if (k == 0) begin
        bb_byte(WIPER_ADDR, 1'b1, r, a);
        `CHECK("rd addr ack", 1'b1, a)
      end
    end
    for (int n = 0; n < 3; n++) begin
      bb_byte(8'hff, (n == 2), r, a);
      `CHECK("rd data", model2, r)
    end
    busB.sdaMasterOe <= 1'b1;
    bb_half();
    busB.sclOe <= 1'b0;
    bb_half();
    busB.sdaMasterOe <= 1'b0;
    bb_half();
  endtask
  initial begin
    #300000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    busB.sclOe = 1'b0;
    busB.sdaMasterOe = 1'b0;
    void'($urandom(32'h2252ab69));
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    `CHECK("reset", WIPER_RESET, wiperPos)
    model = WIPER_RESET;
    model2 = WIPER_RESET;
    cmd(1'b1, 8'h00);
    cmd(1'b0, 8'h00);
    cmd(1'b0, 8'hff);
    cmd(1'b1, 8'h00);
    $display("test corner done");
    repeat (10) cmd(1'($urandom_range(1)), 8'($urandom));
    $display("test random done");
    bb_xfer(8'h52, 8'h00, 8'h5a);
    bb_xfer(8'h51, 8'h00, 8'h5a);
    bb_xfer(8'h50, 8'h01, 8'h5a);
    bb_xfer(8'h50, 8'h00, 8'h3c);
    bb_read();
    $display("test scripted done");
    rst_b <= 1'b0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    `CHECK("rereset", WIPER_RESET, wiperPos2)
    `CHECK("rereset main", WIPER_RESET, wiperPos)
    model = WIPER_RESET;
    cmd(1'b1, 8'h00);
    $display("test second reset done");
    end_sim();
  end
endmodule
`default_nettype wire
